// File: core/ncp_neuron.sv
`timescale 1ns/1ps
`include "ncp_defines.svh"

module ncp_neuron import ncp_pkg::*; #(
  parameter int MEM_DEPTH = 256,
  parameter logic [15:0] NEURON_ID = 16'h0001 // Arbitrary value, set per neuron
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic DATA_STROBE,
  input wire logic RW_READ,
  input wire logic [4:0] REG_SEL,
  input wire logic [15:0] DATA_IN,
  output logic [15:0] DATA_OUT,
  output logic DATA_OE_N,
  output logic RDY_OE_N,
  output logic AGREED_MATCH_OE_N,
  input wire logic CONFLICT_MATCH_IN_N,
  output logic CONFLICT_MATCH_OE_N,
  input wire logic CHAIN_IN,
  output logic CHAIN_OUT
);

  localparam int IW = $clog2(MEM_DEPTH);

  ncp_seq_e st_r;
  ncp_seq_e st_nxt;
  ncp_chain_e chain_st;
  logic [4:0] cnt_r;
  logic [4:0] reg_r;
  logic rd_r;
  logic [15:0] wdat_r;
  logic [7:0] mem_r [MEM_DEPTH];
  logic [IW-1:0] idx_r;
  logic [15:0] label_r;
  logic [15:0] aif_r;
  logic [15:0] lfb_r;
  logic [15:0] maxif_r;
  logic [15:0] gcr_r;
  logic [6:0] ctx_r;
  logic sr_r;
  logic knn_r;
  logic id_r;
  logic unc_r;
  logic committed_r;
  logic sr_done_r;
  logic reported_r;
  logic last_win_r;
  logic settle_r;
  logic any_fire_r;
  logic [15:0] agreed_label_r;
  logic [15:0] data_out_r;
  logic data_oe_n_r;
  logic rdy_oe_n_r;
  logic agree_oe_n_r;
  logic conflict_oe_n_r;
  logic chain_out_r;
  logic [15:0] data_out_nxt;
  logic data_oe_n_nxt;
  logic [15:0] match_gap_reg;
  logic in_race_r;
  logic in_race_nxt;

  function automatic logic [4:0] cmd_len(input logic rd, input logic [4:0] r, input logic sr);
    logic [4:0] n;
    n = `NCP_CYC_SINGLE;
    if (!sr) begin
      if (!rd && r == `NCP_REG_FINAL) begin
        n = `NCP_CYC_FINAL_WR;
      end else if (!rd && r == `NCP_REG_LABEL) begin
        n = `NCP_CYC_LABEL_WR;
      end else if (rd && r == `NCP_REG_GAP) begin
        n = `NCP_CYC_GAP_RD;
      end else if (rd && r == `NCP_REG_LABEL) begin
        n = `NCP_CYC_LABEL_RD;
      end
    end
    return n;
  endfunction

  // Command capture and chain state
  wire take = (st_r == ST_IDLE) && DATA_STROBE;
  wire wr_now = take && !RW_READ;
  wire rd_now = take && RW_READ;
  wire finish = (st_r == ST_EXEC) && (cnt_r == 5'h00);
  wire candidate = CHAIN_IN && !committed_r;
  wire sel = sr_r && CHAIN_IN && !sr_done_r;
  assign chain_st = committed_r ? CH_COMMITTED : (candidate ? CH_CANDIDATE : CH_IDLE);

  wire w_comp = wr_now && (REG_SEL == `NCP_REG_COMP);
  wire w_final = wr_now && (REG_SEL == `NCP_REG_FINAL) && !sr_r;
  wire w_index = wr_now && (REG_SEL == `NCP_REG_GAP);
  wire w_label = wr_now && (REG_SEL == `NCP_REG_LABEL);
  wire w_aif = wr_now && (REG_SEL == `NCP_REG_AIF) && sel;
  wire w_lfb = wr_now && (REG_SEL == `NCP_REG_LFB) && (!sr_r || sel);
  wire w_maxif = wr_now && (REG_SEL == `NCP_REG_MAXIF) && !sr_r;
  wire w_gcr = wr_now && (REG_SEL == `NCP_REG_GCR) && !sr_r;
  wire w_restart = wr_now && (REG_SEL == `NCP_REG_RESTART);
  wire w_net = wr_now && (REG_SEL == `NCP_REG_NET);
  wire w_forget = wr_now && (REG_SEL == `NCP_REG_FORGET) && !sr_r;

  // Recognition: committed, same context, inside influence field (or any distance in KNN mode)
  wire ctx_hit = (ctx_r == gcr_r[6:0]);
  wire fire = (chain_st == CH_COMMITTED) && ctx_hit && !sr_r && (knn_r || (match_gap_reg < aif_r));
  wire learn_wr = (w_comp || w_final) && candidate && !sr_r;
  wire match_gap_reg_upd = (w_comp || w_final) && (chain_st == CH_COMMITTED) && ctx_hit && !sr_r;

  // Op in progress, decoded from the captured select
  wire op_final = !rd_r && (reg_r == `NCP_REG_FINAL);
  wire op_label_wr = !rd_r && (reg_r == `NCP_REG_LABEL) && !sr_r;
  wire op_gap_rd = rd_r && (reg_r == `NCP_REG_GAP) && !sr_r;
  wire sort_start = rd_now && (REG_SEL == `NCP_REG_GAP) && !sr_r;
  wire sort_step = (st_r == ST_EXEC) && op_gap_rd && (cnt_r != 5'h00)
    && (cnt_r <= `NCP_SORT_LAST);
  wire [3:0] sort_bit = 4'(cnt_r - 5'h01);
  wire win = in_race_r && !reported_r;

  // Learning outcome at the end of a label write
  wire novel = !(id_r && (agreed_label_r[14:0] == wdat_r[14:0]));
  wire do_commit = finish && op_label_wr && candidate && (wdat_r != 16'h0000) && novel;
  wire do_shrink = finish && op_label_wr && fire && (label_r[14:0] != wdat_r[14:0])
    && (match_gap_reg < aif_r);
  wire sr_label_wr = w_label && sel;

  // Read decode
  wire r_net = (reg_r == `NCP_REG_NET);
  wire r_gcr = (reg_r == `NCP_REG_GCR);
  wire r_lfb = (reg_r == `NCP_REG_LFB);
  wire r_max = (reg_r == `NCP_REG_MAXIF);
  wire r_gap = (reg_r == `NCP_REG_GAP);
  wire r_lab = (reg_r == `NCP_REG_LABEL);
  wire r_aif = (reg_r == `NCP_REG_AIF);
  wire r_nid = (reg_r == `NCP_REG_NID);
  wire r_comp = (reg_r == `NCP_REG_COMP);
  wire [15:0] net_word = {10'h000, knn_r, sr_r, id_r, unc_r, 2'b00};
  // Shared registers hold equal values everywhere, so all neurons drive them outside save/restore mode
  wire rd_drive = rd_r && ((!sr_r && (r_net || r_gcr || r_lfb || r_max))
    || (!sr_r && win && (r_gap || r_lab)) || (!sr_r && last_win_r && r_nid)
    || (sel && (r_comp || r_gap || r_lab || r_aif || r_lfb || r_nid)));
  wire [15:0] rd_val = r_net ? net_word : r_gcr ? gcr_r : r_lfb ? lfb_r :
    r_max ? maxif_r : r_gap ? match_gap_reg : r_lab ? label_r : r_aif ? aif_r :
    r_nid ? NEURON_ID : {8'h00, mem_r[idx_r]};

  ncp_match_gap_reg_acc u_match_gap_reg (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .upd(match_gap_reg_upd),
    .clear(idx_r == '0),
    .norm_sup(gcr_r[`NCP_GCR_NORM_BIT]),
    .comp(DATA_IN[7:0]),
    .stored(mem_r[idx_r]),
    .match_gap_reg_r(match_gap_reg)
  );

  ncp_sort_race #(.W(16)) u_race (
    .clk(CORE_CLK),
    .rst(SYS_RST),
    .start(sort_start),
    .enable(fire && !reported_r),
    .step(sort_step),
    .bit_sel(sort_bit),
    .own(match_gap_reg),
    .bus(DATA_IN),
    .in_race_r(in_race_r),
    .in_race_nxt(in_race_nxt)
  );

  // Sequencer: length set once at capture, ready low until the count expires
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE: begin
        if (take) begin
          st_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (cnt_r == 5'h00) begin
          st_nxt = ST_IDLE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_r <= ST_IDLE;
      cnt_r <= 5'h00;
      reg_r <= 5'h00;
      rd_r <= 1'b1;
      wdat_r <= 16'h0000;
      rdy_oe_n_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      rdy_oe_n_r <= (st_nxt != ST_EXEC);
      if (take) begin
        cnt_r <= cmd_len(RW_READ, REG_SEL, sr_r) - 5'h01;
        reg_r <= REG_SEL;
        rd_r <= RW_READ;
        wdat_r <= DATA_IN;
      end else if (st_r == ST_EXEC && cnt_r != 5'h00) begin
        cnt_r <= cnt_r - 5'h01;
      end
    end
  end

  // Data bus drive: label wired-AND, sort race, then read result
  always_comb begin
    data_out_nxt = data_out_r;
    data_oe_n_nxt = 1'b1;
    if (st_r == ST_EXEC && op_final && cnt_r == 5'h01 && fire) begin
      data_out_nxt = label_r;
      data_oe_n_nxt = 1'b0;
    end else if (st_r == ST_EXEC && op_gap_rd && cnt_r >= 5'h02 && in_race_nxt) begin
      data_out_nxt = match_gap_reg;
      data_oe_n_nxt = 1'b0;
    end else if (finish && rd_drive) begin
      data_out_nxt = rd_val;
      data_oe_n_nxt = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      data_out_r <= `NCP_BUS_IDLE;
      data_oe_n_r <= 1'b1;
      chain_out_r <= 1'b0;
    end else begin
      data_out_r <= data_out_nxt;
      data_oe_n_r <= data_oe_n_nxt;
      chain_out_r <= sr_r ? sr_done_r : committed_r;
    end
  end

  // Recognition status: own verdict at the end, then settle on the wired conflict
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      agree_oe_n_r <= 1'b1;
      conflict_oe_n_r <= 1'b1;
      settle_r <= 1'b0;
      any_fire_r <= 1'b0;
      agreed_label_r <= `NCP_BUS_IDLE;
      id_r <= 1'b0;
      unc_r <= 1'b0;
    end else begin
      settle_r <= finish && op_final;
      if (w_final || w_forget) begin
        agree_oe_n_r <= 1'b1;
        conflict_oe_n_r <= 1'b1;
      end else if (finish && op_final) begin
        agreed_label_r <= DATA_IN;
        any_fire_r <= (DATA_IN != `NCP_BUS_IDLE);
        conflict_oe_n_r <= !(fire && DATA_IN != label_r);
        agree_oe_n_r <= !(fire && DATA_IN == label_r);
      end else if (settle_r) begin
        // Someone else disagreed: withdraw our agreement
        if (!CONFLICT_MATCH_IN_N) begin
          agree_oe_n_r <= 1'b1;
        end
        unc_r <= !CONFLICT_MATCH_IN_N;
        id_r <= any_fire_r && CONFLICT_MATCH_IN_N;
      end
    end
  end

  // Neuron memory
  always_ff @(posedge CORE_CLK) begin
    if (learn_wr || (w_comp && sel)) begin
      mem_r[idx_r] <= DATA_IN[7:0];
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      idx_r <= '0;
    end else if (w_final || w_forget) begin
      idx_r <= '0;
    end else if (w_index) begin
      idx_r <= DATA_IN[IW-1:0];
    end else if (w_comp || (finish && rd_r && r_comp && sr_r)) begin
      idx_r <= idx_r + 1'b1;
    end
  end

  // Shared settings
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      gcr_r <= `NCP_RST_GCR;
      lfb_r <= `NCP_RST_LFB;
      maxif_r <= `NCP_RST_MAXIF;
      sr_r <= 1'b0;
      knn_r <= 1'b0;
    end else begin
      if (w_gcr) begin
        gcr_r <= DATA_IN;
      end
      if (w_lfb) begin
        lfb_r <= DATA_IN;
      end
      if (w_maxif) begin
        maxif_r <= DATA_IN;
      end
      if (w_net) begin
        sr_r <= DATA_IN[`NCP_NET_SR_BIT];
        knn_r <= DATA_IN[`NCP_NET_KNN_BIT];
      end
    end
  end

  // Per-neuron model: label, field, context, chain flags
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      label_r <= `NCP_RST_LABEL;
      aif_r <= `NCP_RST_AIF;
      ctx_r <= `NCP_RST_CTX;
      committed_r <= 1'b0;
    end else if (w_forget) begin
      label_r <= `NCP_RST_LABEL;
      aif_r <= `NCP_RST_AIF;
      committed_r <= 1'b0;
    end else if (sr_label_wr) begin
      label_r <= DATA_IN;
      committed_r <= (DATA_IN != 16'h0000);
    end else if (do_commit) begin
      label_r <= wdat_r;
      aif_r <= maxif_r;
      ctx_r <= gcr_r[6:0];
      committed_r <= 1'b1;
    end else if (do_shrink) begin
      aif_r <= (match_gap_reg > lfb_r) ? match_gap_reg : lfb_r;
      if (match_gap_reg <= lfb_r) begin
        label_r[`NCP_LABEL_DEGEN_BIT] <= 1'b1;
      end
    end else if (w_aif) begin
      aif_r <= DATA_IN;
    end else if (wr_now && REG_SEL == `NCP_REG_NID && sel) begin
      ctx_r <= DATA_IN[6:0];
    end
  end

  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sr_done_r <= 1'b0;
      reported_r <= 1'b0;
      last_win_r <= 1'b0;
    end else begin
      if (w_restart || w_net) begin
        sr_done_r <= 1'b0;
      end else if (sr_label_wr || (finish && rd_r && r_lab && sel)) begin
        sr_done_r <= 1'b1;
      end
      if (w_final || w_forget) begin
        reported_r <= 1'b0;
        last_win_r <= 1'b0;
      end else if (finish && rd_r && r_lab && !sr_r) begin
        reported_r <= reported_r || in_race_r;
        last_win_r <= win;
      end
    end
  end

  assign DATA_OUT = data_out_r;
  assign DATA_OE_N = data_oe_n_r;
  assign RDY_OE_N = rdy_oe_n_r;
  assign AGREED_MATCH_OE_N = agree_oe_n_r;
  assign CONFLICT_MATCH_OE_N = conflict_oe_n_r;
  assign CHAIN_OUT = chain_out_r;

endmodule

// File: core/ncp_defines.svh
`ifndef NCP_DEFINES_SVH
`define NCP_DEFINES_SVH

// Register select codes
`define NCP_REG_COMP 5'h01
`define NCP_REG_FINAL 5'h02
`define NCP_REG_GAP 5'h03
`define NCP_REG_LABEL 5'h04
`define NCP_REG_AIF 5'h05
`define NCP_REG_LFB 5'h06
`define NCP_REG_MAXIF 5'h07
`define NCP_REG_NID 5'h0A
`define NCP_REG_GCR 5'h0B
`define NCP_REG_RESTART 5'h0C
`define NCP_REG_NET 5'h0D
`define NCP_REG_FORGET 5'h0F

// Network status, global control and label fields
`define NCP_NET_UNC_BIT 2
`define NCP_NET_ID_BIT 3
`define NCP_NET_SR_BIT 4
`define NCP_NET_KNN_BIT 5
`define NCP_GCR_NORM_BIT 7
`define NCP_LABEL_DEGEN_BIT 15

// Reset values
`define NCP_RST_GCR 16'h0001
`define NCP_RST_LFB 16'h0002
`define NCP_RST_MAXIF 16'h4000
`define NCP_RST_AIF 16'h4000
`define NCP_RST_GAP 16'hFFFF
`define NCP_RST_LABEL 16'hFFFF
`define NCP_RST_CTX 7'h01
`define NCP_BUS_IDLE 16'hFFFF

// Command lengths in clock cycles
`define NCP_CYC_SINGLE 5'h01
`define NCP_CYC_FINAL_WR 5'h02
`define NCP_CYC_LABEL_WR 5'h13
`define NCP_CYC_GAP_RD 5'h12
`define NCP_CYC_LABEL_RD 5'h02
`define NCP_SORT_LAST 5'h10

`endif

// File: core/ncp_pkg.sv
package ncp_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01
  } ncp_seq_e;

  typedef enum logic [1:0] {
    CH_IDLE = 2'b00,
    CH_CANDIDATE = 2'b01,
    CH_COMMITTED = 2'b10
  } ncp_chain_e;

endpackage

// File: core/ncp_match_gap_reg_acc.sv
`timescale 1ns/1ps
`include "ncp_defines.svh"

module ncp_match_gap_reg_acc (
  input wire logic clk,
  input wire logic rst,
  input wire logic upd,
  input wire logic clear,
  input wire logic norm_sup,
  input wire logic [7:0] comp,
  input wire logic [7:0] stored,
  output logic [15:0] match_gap_reg_r
);

  wire [7:0] diff = (comp > stored) ? (comp - stored) : (stored - comp);
  wire [15:0] base = clear ? 16'h0000 : match_gap_reg_r;
  wire [16:0] sum = {1'b0, base} + {9'h000, diff};
  // Saturate rather than wrap so a far vector never looks close
  wire [15:0] l1 = sum[16] ? 16'hFFFF : sum[15:0];
  wire [15:0] sup = (base > {8'h00, diff}) ? base : {8'h00, diff};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_gap_reg_r <= `NCP_RST_GAP;
    end else if (upd) begin
      match_gap_reg_r <= norm_sup ? sup : l1;
    end
  end

endmodule

// File: core/ncp_sort_race.sv
`timescale 1ns/1ps

module ncp_sort_race #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic enable,
  input wire logic step,
  input wire logic [$clog2(W)-1:0] bit_sel,
  input wire logic [W-1:0] own,
  input wire logic [W-1:0] bus,
  output logic in_race_r,
  output logic in_race_nxt
);

  // A one on our side against a zero on the wired-AND bus means a smaller value exists
  always_comb begin
    in_race_nxt = in_race_r;
    if (start) begin
      in_race_nxt = enable;
    end else if (step && in_race_r && own[bit_sel] && !bus[bit_sel]) begin
      in_race_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_race_r <= 1'b0;
    end else begin
      in_race_r <= in_race_nxt;
    end
  end

endmodule

// File: sim/ncp_neuron_checker.sv
`timescale 1ns/1ps
`include "ncp_defines.svh"
module ncp_neuron_checker #(
  parameter int MEM_DEPTH = 256
) (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic DATA_STROBE,
  input wire logic RW_READ,
  input wire logic [4:0] REG_SEL,
  input wire logic [15:0] DATA_IN,
  input wire logic [15:0] DATA_OUT,
  input wire logic DATA_OE_N,
  input wire logic RDY_OE_N,
  input wire logic AGREED_MATCH_OE_N,
  input wire logic CONFLICT_MATCH_IN_N,
  input wire logic CONFLICT_MATCH_OE_N,
  input wire logic CHAIN_IN,
  input wire logic CHAIN_OUT
);
  logic sr_r;
  logic nz_label_r;
  wire take = DATA_STROBE && RDY_OE_N && DATA_OE_N;
  wire take_wr = take && !RW_READ;
  wire fin_take = take_wr && REG_SEL == `NCP_REG_FINAL && !sr_r;
  wire lbl_wr = take_wr && REG_SEL == `NCP_REG_LABEL && !sr_r;
  wire gap_rd = take && RW_READ && REG_SEL == `NCP_REG_GAP && !sr_r;
  wire long_sel = REG_SEL inside {`NCP_REG_FINAL, `NCP_REG_GAP, `NCP_REG_LABEL};
  // Mode and commit cause tracked so length checks stay exact
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sr_r <= 1'b0;
      nz_label_r <= 1'b0;
    end else begin
      if (take_wr && REG_SEL == `NCP_REG_NET)
        sr_r <= DATA_IN[`NCP_NET_SR_BIT];
      if (lbl_wr && DATA_IN != 16'h0000)
        nz_label_r <= 1'b1;
      else if (fin_take)
        nz_label_r <= 1'b0;
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  chk_take_busy: assert property (take |=> !RDY_OE_N)
    else $error("ready not pulled after a command");
  chk_busy_bound: assert property ($fell(RDY_OE_N) |-> ##[1:19] RDY_OE_N)
    else $error("command ran past 19 cycles");
  chk_single_len: assert property (take && (sr_r || !long_sel) |=> !RDY_OE_N ##1 RDY_OE_N)
    else $error("short command not one cycle");
  chk_final_len: assert property (fin_take |=> !RDY_OE_N [*2] ##1 RDY_OE_N)
    else $error("final element write not two cycles");
  chk_label_len: assert property (lbl_wr |-> ##19 !RDY_OE_N ##1 RDY_OE_N)
    else $error("label write not 19 cycles");
  chk_gap_len: assert property (gap_rd |-> ##18 !RDY_OE_N ##1 RDY_OE_N)
    else $error("gap read not 18 cycles");
  chk_data_slot: assert property (!DATA_OE_N && RDY_OE_N |-> $rose(RDY_OE_N))
    else $error("data driven outside its slot");
  chk_data_once: assert property (!DATA_OE_N && RDY_OE_N |=> DATA_OE_N)
    else $error("read data held over one cycle");
  // Save/restore reuses the token as a walk pointer, so only normal mode rises count
  chk_commit_cause: assert property ($rose(CHAIN_OUT) && !sr_r && !$past(sr_r, 2)
    |-> CHAIN_IN && nz_label_r)
    else $error("chain out rose without commit");
  chk_conflict_time: assert property ($fell(CONFLICT_MATCH_OE_N) |-> $past(fin_take, 3))
    else $error("conflict pulled at wrong time");
  chk_agree_drop: assert property (!AGREED_MATCH_OE_N && !CONFLICT_MATCH_IN_N
    |=> AGREED_MATCH_OE_N)
    else $error("agreement kept under conflict");
endmodule
bind ncp_neuron ncp_neuron_checker #(.MEM_DEPTH(MEM_DEPTH)) u_ncp_chk (
  .CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .DATA_STROBE(DATA_STROBE), .RW_READ(RW_READ),
  .REG_SEL(REG_SEL), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
  .RDY_OE_N(RDY_OE_N), .AGREED_MATCH_OE_N(AGREED_MATCH_OE_N),
  .CONFLICT_MATCH_IN_N(CONFLICT_MATCH_IN_N), .CONFLICT_MATCH_OE_N(CONFLICT_MATCH_OE_N),
  .CHAIN_IN(CHAIN_IN), .CHAIN_OUT(CHAIN_OUT));

// File: sim/ncp_host_model.sv
`timescale 1ns/1ps
module ncp_host_model (
  input wire logic drv_strobe,
  input wire logic drv_read,
  input wire logic [4:0] drv_sel,
  input wire logic [15:0] drv_data,
  input wire logic [15:0] ext_data_and,
  input wire logic ext_conflict_n,
  input wire logic [15:0] nrn_data,
  input wire logic nrn_data_oe_n,
  input wire logic nrn_rdy_oe_n,
  input wire logic nrn_conflict_oe_n,
  output logic data_strobe,
  output logic rw_read,
  output logic [4:0] reg_sel,
  output logic [15:0] data_bus,
  output logic conflict_n,
  output logic rdy
);
  logic [15:0] host_drv;
  logic [15:0] nrn_drv;
  assign data_strobe = drv_strobe;
  assign rw_read = drv_strobe ? drv_read : 1'b1;
  // Select garbled outside the strobe so a late sample shows up
  assign reg_sel = drv_strobe ? drv_sel : ~drv_sel;
  assign host_drv = (drv_strobe && !drv_read) ? drv_data : 16'hFFFF;
  assign nrn_drv = nrn_data_oe_n ? 16'hFFFF : nrn_data;
  assign data_bus = host_drv & nrn_drv & ext_data_and;
  assign rdy = nrn_rdy_oe_n;
  assign conflict_n = nrn_conflict_oe_n & ext_conflict_n;
endmodule

// File: sim/tb_neuron_chain_parallel_bus.sv
`timescale 1ns/1ps
`include "ncp_defines.svh"
module tb_neuron_chain_parallel_bus;
  typedef struct {logic rd; logic [4:0] sel; logic [15:0] d; logic [15:0] q; int n;} ncp_row_s;
  logic clk, rst, s, r, chain_in, ext_unc_n;
  logic [4:0] sl;
  logic [15:0] dd, ext_and, q, busy_bus;
  wire strobe, rw, unc_n, rdy, doe_n, agr_oe_n, unc_oe_n, cout;
  wire [4:0] rsel;
  wire [15:0] bus, dout;
  int err_count, n_compared, n;
  ncp_row_s rows [11] = '{
    '{1'b1, `NCP_REG_LABEL, 16'h0000, 16'hFFFF, 2},
    '{1'b1, `NCP_REG_LFB, 16'h0000, 16'h0002, 1},
    '{1'b1, `NCP_REG_MAXIF, 16'h0000, 16'h4000, 1},
    '{1'b1, `NCP_REG_GCR, 16'h0000, 16'h0001, 1},
    '{1'b1, `NCP_REG_NET, 16'h0000, 16'h0000, 1},
    '{1'b1, `NCP_REG_GAP, 16'h0000, 16'hFFFF, 18},
    '{1'b1, 5'h0E, 16'h0000, 16'hFFFF, 1},
    '{1'b0, `NCP_REG_LFB, 16'h0005, 16'h0000, 1},
    '{1'b1, `NCP_REG_LFB, 16'h0000, 16'h0005, 1},
    '{1'b0, `NCP_REG_MAXIF, 16'h3000, 16'h0000, 1},
    '{1'b1, `NCP_REG_MAXIF, 16'h0000, 16'h3000, 1}};
  ncp_host_model u_host (.drv_strobe(s), .drv_read(r), .drv_sel(sl), .drv_data(dd),
    .ext_data_and(ext_and), .ext_conflict_n(ext_unc_n), .nrn_data(dout),
    .nrn_data_oe_n(doe_n), .nrn_rdy_oe_n(rdy), .nrn_conflict_oe_n(unc_oe_n),
    .data_strobe(strobe), .rw_read(rw), .reg_sel(rsel), .data_bus(bus),
    .conflict_n(unc_n), .rdy());
  ncp_neuron #(.NEURON_ID(16'h0003)) DUT (.CORE_CLK(clk), .SYS_RST(rst), .DATA_STROBE(strobe),
    .RW_READ(rw), .REG_SEL(rsel), .DATA_IN(bus), .DATA_OUT(dout), .DATA_OE_N(doe_n),
    .RDY_OE_N(rdy), .AGREED_MATCH_OE_N(agr_oe_n), .CONFLICT_MATCH_IN_N(unc_n),
    .CONFLICT_MATCH_OE_N(unc_oe_n), .CHAIN_IN(chain_in), .CHAIN_OUT(cout));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk16(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task automatic chk1(input logic e, input logic g);
    chk16({15'h0000, e}, {15'h0000, g});
  endtask
  task automatic chkn(input int e, input int g);
    chk16(e[15:0], g[15:0]);
  endtask
  // One command; the extra idle cycle keeps clear of the read data slot
  task automatic cmd(input logic rdv, input logic [4:0] sv, input logic [15:0] dv);
    @(negedge clk);
    s = 1'b1;
    r = rdv;
    sl = sv;
    dd = dv;
    @(negedge clk);
    s = 1'b0;
    n = 0;
    while (rdy !== 1'b1 && n < 40) begin
      busy_bus = bus;
      n++;
      @(negedge clk);
    end
    q = bus;
    @(negedge clk);
  endtask
  task automatic vec();
    cmd(1'b0, `NCP_REG_COMP, 16'h0010);
    cmd(1'b0, `NCP_REG_COMP, 16'h0020);
    cmd(1'b0, `NCP_REG_FINAL, 16'h0030);
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // 32 commands of at most 22 cycles each, with generous slack
  initial begin
    #(40 * 4000);
    err_count++;
    results();
  end
  initial begin
    rst = 1'b1;
    {s, sl, dd} = '0;
    {r, chain_in, ext_unc_n} = 3'b111;
    ext_and = 16'hFFFF;
    err_count = 0;
    n_compared = 0;
    repeat (20) @(negedge clk);
    chk1(1'b1, doe_n);
    chk1(1'b1, rdy);
    chk1(1'b0, cout);
    rst = 1'b0;
    for (int i = 0; i < 11; i++) begin
      cmd(rows[i].rd, rows[i].sel, rows[i].d);
      chkn(rows[i].n, n);
      if (rows[i].rd) chk16(rows[i].q, q);
    end
    vec();
    chkn(2, n);
    cmd(1'b0, `NCP_REG_LABEL, 16'h0000);
    chkn(19, n);
    chk1(1'b0, cout);
    vec();
    cmd(1'b0, `NCP_REG_LABEL, 16'h0007);
    chk1(1'b1, cout);
    vec();
    chk16(16'h0007, busy_bus);
    chk1(1'b0, agr_oe_n);
    chk1(1'b1, unc_oe_n);
    cmd(1'b1, `NCP_REG_NET, 16'h0000);
    chk16(16'h0008, q);
    cmd(1'b1, `NCP_REG_GAP, 16'h0000);
    chk16(16'h0000, q);
    cmd(1'b1, `NCP_REG_LABEL, 16'h0000);
    chk16(16'h0007, q);
    ext_and = 16'hFFFE;
    vec();
    ext_and = 16'hFFFF;
    chk16(16'h0006, busy_bus);
    chk1(1'b0, unc_oe_n);
    chk1(1'b1, agr_oe_n);
    cmd(1'b1, `NCP_REG_NET, 16'h0000);
    chk16(16'h0004, q);
    cmd(1'b0, `NCP_REG_NET, 16'h0010);
    cmd(1'b1, `NCP_REG_LABEL, 16'h0000);
    chkn(1, n);
    rst = 1'b1;
    @(negedge clk);
    chk1(1'b1, rdy);
    chk1(1'b0, cout);
    chk1(1'b1, unc_oe_n);
    rst = 1'b0;
    cmd(1'b1, `NCP_REG_NET, 16'h0000);
    chk16(16'h0000, q);
    results();
  end
endmodule
